// ---- include/ard_pkg.sv ----
// Purpose: Shared constants and carriers for the record-read decoder
// Assumes: One byte per transfer on both streams
// Notes:   Status words are SW1 in the upper byte
`default_nettype none
package ard_pkg;
  localparam int unsigned REC_BYTES = 32;
  localparam int unsigned REC_N     = 8;
  localparam int unsigned FNUM_W    = 5;
  localparam int unsigned CNT_W     = 9;

  localparam logic [7:0] CLA_RR   = 8'h00;
  localparam logic [7:0] CLA_BAD  = 8'hff;
  localparam logic [7:0] INS_RR   = 8'hb2;
  localparam logic [3:0] INS_HI_A = 4'h6;
  localparam logic [3:0] INS_HI_B = 4'h9;
  localparam logic [2:0] P2_RECNO = 3'h4;
  localparam logic [4:0] FNUM_MIN = 5'h01;
  localparam logic [4:0] FNUM_MAX = 5'h1e;
  localparam logic [7:0] TAG_APP  = 8'h61;
  localparam logic [7:0] TAG_DISC = 8'h73;
  localparam logic [4:0] DIR_FNUM = 5'h01;

  localparam logic [8:0] POS_CLA = 9'h000;
  localparam logic [8:0] POS_INS = 9'h001;
  localparam logic [8:0] POS_P1  = 9'h002;
  localparam logic [8:0] POS_P2  = 9'h003;

  localparam logic [8:0] N_HDR  = 9'h004;
  localparam logic [8:0] N_LE   = 9'h005;
  localparam logic [8:0] N_LC   = 9'h006;
  localparam logic [8:0] N_MAX  = 9'h1ff;
  localparam logic [8:0] LE_ALL = 9'h100;

  localparam logic [15:0] SW_OK      = 16'h9000;
  localparam logic [15:0] SW_LEN     = 16'h6700;
  localparam logic [7:0]  SW1_LE_FIX = 8'h6c;
  localparam logic [15:0] SW_P1P2    = 16'h6a86;
  localparam logic [15:0] SW_NOREC   = 16'h6a83;
  localparam logic [15:0] SW_INS     = 16'h6d00;
  localparam logic [15:0] SW_CLA     = 16'h6e00;
  localparam logic [15:0] SW_DIAG    = 16'h6f00;

  typedef enum logic [1:0] {
    CASE_1,
    CASE_2,
    CASE_3,
    CASE_4
  } ard_case_t;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
  } ard_hdr_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } ard_byte_t;
endpackage : ard_pkg
`default_nettype wire

// ---- rtl/ard_rec_store.sv ----
// Purpose: Record storage for leaf files keyed by file number
// Assumes: Records loaded in byte order from index zero
// Notes:   Asynchronous read; length is last index plus one
`default_nettype none
module ard_rec_store #(
  parameter int unsigned RN = ard_pkg::REC_N,
  parameter int unsigned RB = ard_pkg::REC_BYTES
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_wr,
  input  wire logic [4:0]              i_wr_fnum,
  input  wire logic [$clog2(RN)-1:0]   i_wr_rec,
  input  wire logic [$clog2(RB)-1:0]   i_wr_idx,
  input  wire logic [7:0]              i_wr_data,
  input  wire logic [4:0]              i_rd_fnum,
  input  wire logic [$clog2(RN)-1:0]   i_rd_rec,
  input  wire logic [$clog2(RB)-1:0]   i_rd_idx,
  output var  logic [7:0]              o_rd_data,
  output var  logic [$clog2(RB):0]     o_rd_len,
  output var  logic                    o_dir_loaded
);
  if (RN < 2 || RB < 2 || RB > 256)
  begin : g_bad_size
    $error("ard_rec_store: bad size");
  end

  localparam int unsigned SLOTS = 32 * RN;
  logic [7:0]          mem [SLOTS*RB];
  logic [$clog2(RB):0] len [SLOTS];

  wire [$clog2(SLOTS)-1:0] wslot = {i_wr_fnum, i_wr_rec};
  wire [$clog2(SLOTS)-1:0] rslot = {i_rd_fnum, i_rd_rec};
  wire [$clog2(SLOTS)-1:0] dslot = {ard_pkg::DIR_FNUM, {$clog2(RN){1'b0}}};

  always_ff @(posedge i_clk)
  begin
    if (i_wr)
      mem[{wslot, i_wr_idx}] <= i_wr_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      for (int k = 0; k < SLOTS; k++)
        len[k] <= '0;
    else if (i_wr)
      len[wslot] <= {1'b0, i_wr_idx} + 1'b1;
  end

  assign o_rd_data    = mem[{rslot, i_rd_idx}];
  assign o_rd_len     = len[rslot];
  assign o_dir_loaded = len[dslot] != '0;
endmodule : ard_rec_store
`default_nettype wire

// ---- rtl/ard_skid_buf.sv ----
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock
// Notes:   Outputs come from flops
`default_nettype none
module ard_skid_buf #(
  parameter int unsigned W = 9
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  input  wire logic [W-1:0] i_data,
  output var  logic         o_ready,
  output var  logic         o_valid,
  output var  logic [W-1:0] o_data,
  input  wire logic         i_ready
);
  if (W < 1)
  begin : g_bad_width
    $error("ard_skid_buf: W must be positive");
  end

  logic [W-1:0] spare_reg;
  logic         spare_v_reg;
  wire          take = i_valid && o_ready;
  wire          give = o_valid && i_ready;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_valid     <= 1'b0;
      o_data      <= '0;
      spare_reg   <= '0;
      spare_v_reg <= 1'b0;
      o_ready     <= 1'b1;
    end
    else
    begin
      if (!o_valid || give)
      begin
        o_valid     <= spare_v_reg || take;
        o_data      <= spare_v_reg ? spare_reg : i_data;
        spare_v_reg <= spare_v_reg && take;
        spare_reg   <= i_data;
        o_ready     <= 1'b1;
      end
      else if (take)
      begin
        spare_v_reg <= 1'b1;
        spare_reg   <= i_data;
        o_ready     <= 1'b0;
      end
    end
  end
endmodule : ard_skid_buf
`default_nettype wire

// ---- rtl/ard_top.sv ----
// Purpose: Command unit framing and record-read decoding, card side
// Assumes: Byte streams and record load port share i_clk
// Notes:   One command in flight; response via two-entry buffer
//
// Contract
// - Command starts with class, instruction, two parameters; optional body follows.
// - Lc and Le absent or one byte; Lc counts following data bytes.
// - Le of zero asks for all available data, up to 256 bytes.
// - Response is optional data then SW1 and SW2 status trailer.
// - No body length is sent; consumer derives it from data objects.
// - Four cases: none, response only, command only, both ways.
// - Valid record read returns the addressed record of a linear file.
// - Record read is class 00, instruction B2, P1 record, Le 00; code accepts any Le, answering 6C when a nonzero Le is below the record length.
// - P2 bits b8-b4 file number; b3-b1 equal 100 mean record number.
// - File number is 5 bits, 1 to 30, unique per application.
// - Dedicated file names unique; entry file name starts with app identifier.
// - Leaf file never leads to another file; only dedicated files do.
// - Listing records hold templates tagged 61; others inside tag 73.
// - Payment environment selection response shows listing file presence.
// - Directory node name prefix retrieves the group sharing that prefix.
// - Instruction valid with lsb 0, nibble not 6 or 9; class not FF.
// - Lc when present lies between 1 and 255.
`default_nettype none
module ard_top #(
  parameter int unsigned RN = ard_pkg::REC_N,
  parameter int unsigned RB = ard_pkg::REC_BYTES
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_cmd_valid,
  input  wire logic [7:0]            i_cmd_data,
  input  wire logic                  i_cmd_last,
  output var  logic                  o_cmd_ready,
  output var  logic                  o_rsp_valid,
  output var  logic [7:0]            o_rsp_data,
  output var  logic                  o_rsp_last,
  input  wire logic                  i_rsp_ready,
  input  wire logic                  i_ld_valid,
  input  wire logic [4:0]            i_ld_fnum,
  input  wire logic [$clog2(RN)-1:0] i_ld_rec,
  input  wire logic [$clog2(RB)-1:0] i_ld_idx,
  input  wire logic [7:0]            i_ld_data,
  output var  logic                  o_listing_present,
  output var  logic                  o_case_valid,
  output var  logic [1:0]            o_case
);
  if (RN < 2 || RN > 255 || RB < 2 || RB > 256)
  begin : g_bad_size
    $error("ard_top: bad size");
  end

  localparam int unsigned RW = $clog2(RN);
  localparam int unsigned BW = $clog2(RB);

  typedef enum logic [2:0] {
    ST_RECV,
    ST_EVAL,
    ST_CHECK,
    ST_BODY,
    ST_SW1,
    ST_SW2
  } ard_state_t;

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  ard_state_t          state_reg;
  ard_state_t          state_next;
  ard_pkg::ard_hdr_t   hdr_reg;
  logic [7:0]          b4_reg;
  logic [8:0]          cnt_reg;
  logic [15:0]         sw_reg;
  logic [15:0]         sw_next;
  logic [BW:0]         bidx_reg;
  logic [BW:0]         blen_reg;

  // Command framing
  wire       cmd_take = i_cmd_valid && o_cmd_ready;
  wire [8:0] lc_n3    = {1'b0, b4_reg} + ard_pkg::N_LE;
  wire [8:0] lc_n4    = {1'b0, b4_reg} + ard_pkg::N_LC;
  wire       is_c1    = cnt_reg == ard_pkg::N_HDR;
  wire       is_c2    = cnt_reg == ard_pkg::N_LE;
  wire       lc_ok    = b4_reg != 8'h00;
  wire       is_c3    = lc_ok && cnt_reg == lc_n3;
  wire       is_c4    = lc_ok && cnt_reg == lc_n4;
  wire       len_bad  = !(is_c1 || is_c2 || is_c3 || is_c4);

  ard_pkg::ard_case_t case_w;
  assign case_w = is_c1 ? ard_pkg::CASE_1 :
                  is_c2 ? ard_pkg::CASE_2 :
                  is_c3 ? ard_pkg::CASE_3 : ard_pkg::CASE_4;

  // Header checks
  wire [3:0] ins_hi  = hdr_reg.ins[7:4];
  wire       cla_bad = hdr_reg.cla == ard_pkg::CLA_BAD;
  wire       ins_bad = hdr_reg.ins[0] || ins_hi == ard_pkg::INS_HI_A ||
                       ins_hi == ard_pkg::INS_HI_B;
  wire       is_rr   = hdr_reg.ins == ard_pkg::INS_RR;
  wire       rr_cla  = hdr_reg.cla == ard_pkg::CLA_RR;

  // Reference control parameter
  wire [4:0] fnum_w  = hdr_reg.p2[7:3];
  wire       p2_ok   = hdr_reg.p2[2:0] == ard_pkg::P2_RECNO;
  wire       fnum_ok = fnum_w >= ard_pkg::FNUM_MIN &&
                       fnum_w <= ard_pkg::FNUM_MAX;
  wire       p1_ok   = hdr_reg.p1 != 8'h00 && {1'b0, hdr_reg.p1} <= 9'(RN);
  wire [RW-1:0] rec_w = RW'(hdr_reg.p1 - 8'h01);

  // Le of zero widens to the full 256-byte request
  wire [8:0] le_eff = (b4_reg == 8'h00) ? ard_pkg::LE_ALL :
                      {1'b0, b4_reg};

  // Record storage, one slot per file number and record
  logic [7:0] st_data;
  logic [BW:0] st_len;
  logic st_dir;

  ard_rec_store #(
    .RN (RN),
    .RB (RB)
  ) ard_rec_store_inst (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_wr         (i_ld_valid),
    .i_wr_fnum    (i_ld_fnum),
    .i_wr_rec     (i_ld_rec),
    .i_wr_idx     (i_ld_idx),
    .i_wr_data    (i_ld_data),
    .i_rd_fnum    (fnum_w),
    .i_rd_rec     (rec_w),
    .i_rd_idx     (bidx_reg[BW-1:0]),
    .o_rd_data    (st_data),
    .o_rd_len     (st_len),
    .o_dir_loaded (st_dir)
  );

  // Listing file content and length checks on the addressed record
  wire is_dir   = fnum_w == ard_pkg::DIR_FNUM;
  wire tag_ok   = st_data == ard_pkg::TAG_APP ||
                  st_data == ard_pkg::TAG_DISC;
  wire rec_none = st_len == '0;
  wire le_short = b4_reg != 8'h00 && le_eff < 9'(st_len);

  // Response buffer
  ard_pkg::ard_byte_t rb_in;
  ard_pkg::ard_byte_t rb_out;
  logic rb_ready;
  wire  rb_valid = state_reg == ST_BODY || state_reg == ST_SW1 ||
                   state_reg == ST_SW2;
  wire  rb_push  = rb_valid && rb_ready;

  assign rb_in.data = (state_reg == ST_BODY) ? st_data :
                      (state_reg == ST_SW1) ? sw_reg[15:8] : sw_reg[7:0];
  assign rb_in.last = state_reg == ST_SW2;

  ard_skid_buf #(
    .W ($bits(ard_pkg::ard_byte_t))
  ) ard_skid_buf_inst (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_valid (rb_valid),
    .i_data  (rb_in),
    .o_ready (rb_ready),
    .o_valid (o_rsp_valid),
    .o_data  (rb_out),
    .i_ready (i_rsp_ready)
  );

  assign o_rsp_data = rb_out.data;
  assign o_rsp_last = rb_out.last;

  // Status selection after framing
  logic go_check;

  always_comb
  begin
    sw_next  = sw_reg;
    go_check = 1'b0;
    if (len_bad)
      sw_next = ard_pkg::SW_LEN;
    else if (cla_bad)
      sw_next = ard_pkg::SW_CLA;
    else if (ins_bad || !is_rr)
      sw_next = ard_pkg::SW_INS;
    else if (!rr_cla)
      sw_next = ard_pkg::SW_CLA;
    else if (case_w != ard_pkg::CASE_2)
      sw_next = ard_pkg::SW_LEN;
    else if (!p2_ok || !fnum_ok)
      sw_next = ard_pkg::SW_P1P2;
    else if (!p1_ok)
      sw_next = ard_pkg::SW_NOREC;
    else
      go_check = 1'b1;
  end

  // Sequencing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RECV:
        if (cmd_take && i_cmd_last)
          state_next = ST_EVAL;
      ST_EVAL:
        state_next = go_check ? ST_CHECK : ST_SW1;
      ST_CHECK:
        if (rec_none || (is_dir && !tag_ok) || le_short)
          state_next = ST_SW1;
        else
          state_next = ST_BODY;
      ST_BODY:
        if (rb_push && bidx_reg + 1'b1 == blen_reg)
          state_next = ST_SW1;
      ST_SW1:
        if (rb_push)
          state_next = ST_SW2;
      ST_SW2:
        if (rb_push)
          state_next = ST_RECV;
      default:
        state_next = ST_RECV;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= ST_RECV;
    else
      state_reg <= state_next;
  end

  // Header byte position decode
  wire at_cla  = cmd_take && cnt_reg == ard_pkg::POS_CLA;
  wire at_ins  = cmd_take && cnt_reg == ard_pkg::POS_INS;
  wire at_p1   = cmd_take && cnt_reg == ard_pkg::POS_P1;
  wire at_p2   = cmd_take && cnt_reg == ard_pkg::POS_P2;
  wire at_len  = cmd_take && cnt_reg == ard_pkg::N_HDR;
  wire cnt_inc = cmd_take && cnt_reg != ard_pkg::N_MAX;
  wire cnt_clr = state_reg == ST_SW2 && rb_push;
  wire case_upd = state_reg == ST_EVAL && !len_bad;

  // Header capture by byte position
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdr_reg <= '0;
      b4_reg  <= 8'h00;
      cnt_reg <= '0;
    end
    else
    begin
      if (at_cla)
        hdr_reg.cla <= i_cmd_data;
      if (at_ins)
        hdr_reg.ins <= i_cmd_data;
      if (at_p1)
        hdr_reg.p1 <= i_cmd_data;
      if (at_p2)
        hdr_reg.p2 <= i_cmd_data;
      if (at_len)
        b4_reg <= i_cmd_data;
      if (cnt_clr)
        cnt_reg <= '0;
      else if (cnt_inc)
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Status word and body length
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_reg   <= ard_pkg::SW_OK;
      blen_reg <= '0;
    end
    else if (state_reg == ST_EVAL)
      sw_reg <= sw_next;
    else if (state_reg == ST_CHECK)
    begin
      blen_reg <= st_len;
      if (rec_none)
        sw_reg <= ard_pkg::SW_NOREC;
      else if (is_dir && !tag_ok)
        sw_reg <= ard_pkg::SW_DIAG;
      else if (le_short)
        sw_reg <= {ard_pkg::SW1_LE_FIX, 8'(st_len)};
      else
        sw_reg <= ard_pkg::SW_OK;
    end
  end

  // Body byte index
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      bidx_reg <= '0;
    else if (state_reg == ST_BODY && rb_push)
      bidx_reg <= bidx_reg + 1'b1;
    else if (state_reg != ST_BODY)
      bidx_reg <= '0;
  end

  // Leaf files are reached only by file number; nothing chains onward
  // from a record, and the listing file shows through its own slot.
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_cmd_ready       <= 1'b0;
      o_listing_present <= 1'b0;
      o_case_valid      <= 1'b0;
      o_case            <= 2'h0;
    end
    else
    begin
      o_cmd_ready       <= state_next == ST_RECV;
      o_listing_present <= st_dir;
      o_case_valid      <= case_upd;
      if (case_upd)
        o_case <= case_w;
    end
  end
endmodule : ard_top
`default_nettype wire

// ---- tb/ard_term_model.sv ----
// Purpose: Terminal model sending commands, taking responses
// Assumes: Byte stream with valid, ready and last
// Notes:   Receiver may stall every other cycle
`default_nettype none
module ard_term_model (
  input  wire logic       i_clk,
  input  wire logic       i_ready,
  output var  logic       o_valid,
  output var  logic [7:0] o_data,
  output var  logic       o_last,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_data,
  input  wire logic       i_rsp_last,
  output var  logic       o_rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] ard_bq_t[$];
  ard_bq_t rx_q;
  logic    rx_done = 1'b0;
  logic    stall = 1'b0;
  logic    ok;
  int      cyc = 0;
  initial
  begin
    o_valid = 1'b0;
    o_data = 8'h00;
    o_last = 1'b0;
    o_rsp_ready = 1'b1;
  end
  // Falling-edge values are what the next rising edge takes
  always @(negedge i_clk)
    if (i_rsp_valid && o_rsp_ready)
    begin
      rx_q.push_back(i_rsp_data);
      if (i_rsp_last)
        rx_done = 1'b1;
    end
  always @(posedge i_clk)
  begin
    #1;
    cyc++;
    o_rsp_ready = !stall || cyc[0];
  end
  task automatic send(input ard_bq_t b);
    rx_q.delete();
    rx_done = 1'b0;
    @(posedge i_clk);
    #1;
    foreach (b[i])
    begin
      o_valid = 1'b1;
      o_data = b[i];
      o_last = (i == b.size() - 1);
      do
      begin
        @(negedge i_clk);
        ok = i_ready;
        @(posedge i_clk);
      end
      while (!ok);
      #1;
    end
    o_valid = 1'b0;
    o_last = 1'b0;
    o_data = ~o_data;
  endtask : send
endmodule : ard_term_model
`default_nettype wire

// ---- tb/ard_top_assertions.sv ----
// Purpose: Port checks for the record-read decoder
// Assumes: One clock, active-low reset
// Notes:   Bound into ard_top
`default_nettype none
module ard_top_checker (
  input wire logic       i_clk,
  input wire logic       i_resetn,
  input wire logic       i_cmd_valid,
  input wire logic       i_cmd_last,
  input wire logic       o_cmd_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_data,
  input wire logic       o_rsp_last,
  input wire logic       i_rsp_ready,
  input wire logic       o_case_valid,
  input wire logic [1:0] o_case
);
  logic last_in;
  logic rsp_end;
  assign last_in = i_cmd_valid && o_cmd_ready && i_cmd_last;
  assign rsp_end = o_rsp_valid && o_rsp_last && i_rsp_ready;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_rsp_hold: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable({o_rsp_data, o_rsp_last}))
    else $error("stalled byte changed");
  a_ready_drop: assert property (last_in |=> !o_cmd_ready)
    else $error("ready after last byte");
  a_first_gap: assert property (last_in |=> !o_rsp_valid [*2])
    else $error("response too early");
  a_answer_bound: assert property (last_in |-> ##[3:250] rsp_end)
    else $error("trailer missing");
  a_rsp_quiet: assert property (rsp_end |=> !o_rsp_valid)
    else $error("byte after trailer");
  a_case_pulse: assert property (o_case_valid |=> !o_case_valid)
    else $error("case pulse too long");
  a_case_busy: assert property (o_case_valid |-> !o_cmd_ready)
    else $error("case flagged while idle");
  a_case_hold: assert property (!o_case_valid |-> $stable(o_case))
    else $error("case code moved");
  c_stall: cover property (o_rsp_valid && !i_rsp_ready);
  c_case4: cover property (o_case_valid && o_case == 2'h3);
  c_end: cover property (rsp_end);
endmodule : ard_top_checker
bind ard_top ard_top_checker ard_top_checker_inst (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd_last, .o_cmd_ready,
  .o_rsp_valid, .o_rsp_data, .o_rsp_last, .i_rsp_ready, .o_case_valid, .o_case);
`default_nettype wire

// ---- tb/ard_top_tb.sv ----
// Purpose: Self-checking bench for the record-read decoder
// Assumes: Terminal model drives the command stream
// Notes:   Inputs change 1 ns after the rising edge
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module ard_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] ard_bq_t[$];
  localparam logic [2:0] C1 = 3'h4;
  localparam logic [2:0] C2 = 3'h5;
  localparam logic [2:0] C3 = 3'h6;
  localparam logic [2:0] C4 = 3'h7;
  localparam logic [2:0] CN = 3'h0;
  logic       i_clk;
  logic       i_resetn;
  logic       i_cmd_valid;
  logic [7:0] i_cmd_data;
  logic       i_cmd_last;
  logic       o_cmd_ready;
  logic       o_rsp_valid;
  logic [7:0] o_rsp_data;
  logic       o_rsp_last;
  logic       i_rsp_ready;
  logic       i_ld_valid;
  logic [4:0] i_ld_fnum;
  logic [2:0] i_ld_rec;
  logic [4:0] i_ld_idx;
  logic [7:0] i_ld_data;
  logic       o_listing_present;
  logic       o_case_valid;
  logic [1:0] o_case;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  int         case_cnt = 0;
  logic [1:0] case_seen = 2'h0;
  ard_bq_t    rec_a = '{8'h11, 8'h22, 8'h33};
  ard_bq_t    rec_b = '{8'haa};
  ard_bq_t    rec_c = '{8'h61, 8'h02, 8'h4f, 8'h00};

  ard_top ard_top_inst (.i_clk, .i_resetn, .i_cmd_valid, .i_cmd_data, .i_cmd_last, .o_cmd_ready,
    .o_rsp_valid, .o_rsp_data, .o_rsp_last, .i_rsp_ready, .i_ld_valid, .i_ld_fnum, .i_ld_rec,
    .i_ld_idx, .i_ld_data, .o_listing_present, .o_case_valid, .o_case);
  ard_term_model ard_term_model_inst (.i_clk, .i_ready(o_cmd_ready), .o_valid(i_cmd_valid),
    .o_data(i_cmd_data), .o_last(i_cmd_last), .i_rsp_valid(o_rsp_valid), .i_rsp_data(o_rsp_data),
    .i_rsp_last(o_rsp_last), .o_rsp_ready(i_rsp_ready));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  always @(negedge i_clk)
    if (o_case_valid)
    begin
      case_seen = o_case;
      case_cnt++;
    end

  function automatic ard_bq_t rr(input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] le);
    return '{8'h00, 8'hb2, p1, p2, le};
  endfunction : rr
  function automatic ard_bq_t sw(input logic [15:0] s);
    return '{s[15:8], s[7:0]};
  endfunction : sw
  function automatic ard_bq_t ok(input ard_bq_t d);
    d.push_back(8'h90);
    d.push_back(8'h00);
    return d;
  endfunction : ok

  task automatic load(input logic [4:0] fnum, input logic [2:0] rec, input ard_bq_t b);
    foreach (b[i])
    begin
      i_ld_valid = 1'b1;
      i_ld_fnum = fnum;
      i_ld_rec = rec;
      i_ld_idx = 5'(i);
      i_ld_data = b[i];
      @(posedge i_clk);
      #1;
    end
    i_ld_valid = 1'b0;
  endtask : load

  task automatic xfer(input ard_bq_t c, input ard_bq_t e, input logic [2:0] ec);
    int n0;
    int k;
    n0 = case_cnt;
    ard_term_model_inst.send(c);
    k = 0;
    while (!ard_term_model_inst.rx_done && k < 300)
    begin
      @(posedge i_clk);
      k++;
    end
    `CHK(ard_term_model_inst.rx_q.size(), e.size())
    foreach (e[i]) `CHK(ard_term_model_inst.rx_q[i], e[i])
    `CHK(case_cnt - n0, int'(ec[2]))
    if (ec[2]) `CHK(case_seen, ec[1:0])
  endtask : xfer

  task automatic t_reset();
    repeat (4) @(posedge i_clk);
    #1;
    `CHK(o_cmd_ready, 1'b1)
    `CHK(o_rsp_valid, 1'b0)
    `CHK(o_listing_present, 1'b0)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_load();
    load(5'd5, 3'd1, rec_a);
    load(5'd30, 3'd0, rec_b);
    load(5'd1, 3'd1, '{8'h55, 8'h01});
    `CHK(o_listing_present, 1'b0)
    load(5'd1, 3'd0, rec_c);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_listing_present, 1'b1)
    $display("t_load done");
  endtask : t_load

  task automatic t_read();
    ard_term_model_inst.stall = 1'b1;
    xfer(rr(8'h02, 8'h2c, 8'h00), ok(rec_a), C2);
    xfer(rr(8'h01, 8'hf4, 8'h00), ok(rec_b), C2);
    xfer(rr(8'h01, 8'h0c, 8'h00), ok(rec_c), C2);
    xfer(rr(8'h02, 8'h0c, 8'h00), sw(16'h6f00), C2);
    ard_term_model_inst.stall = 1'b0;
    $display("t_read done");
  endtask : t_read

  task automatic t_le();
    xfer(rr(8'h02, 8'h2c, 8'h02), sw(16'h6c03), C2);
    xfer(rr(8'h02, 8'h2c, 8'h03), ok(rec_a), C2);
    xfer(rr(8'h02, 8'h2c, 8'hff), ok(rec_a), C2);
    $display("t_le done");
  endtask : t_le

  task automatic t_sfi();
    xfer(rr(8'h02, 8'h04, 8'h00), sw(16'h6a86), C2);
    xfer(rr(8'h02, 8'hfc, 8'h00), sw(16'h6a86), C2);
    xfer(rr(8'h02, 8'h2d, 8'h00), sw(16'h6a86), C2);
    xfer(rr(8'h02, 8'h28, 8'h00), sw(16'h6a86), C2);
    $display("t_sfi done");
  endtask : t_sfi

  task automatic t_rec();
    xfer(rr(8'h01, 8'h2c, 8'h00), sw(16'h6a83), C2);
    xfer(rr(8'h00, 8'h2c, 8'h00), sw(16'h6a83), C2);
    xfer(rr(8'h09, 8'h2c, 8'h00), sw(16'h6a83), C2);
    $display("t_rec done");
  endtask : t_rec

  task automatic t_hdr();
    ard_bq_t     c;
    logic [31:0] tbl [6] = '{32'hffb26e00, 32'h80b26e00, 32'h00b36d00, 32'h00626d00, 32'h009a6d00,
      32'h00a46d00};
    foreach (tbl[i])
    begin
      c = rr(8'h02, 8'h2c, 8'h00);
      c[0] = tbl[i][31:24];
      c[1] = tbl[i][23:16];
      xfer(c, sw(tbl[i][15:0]), C2);
    end
    $display("t_hdr done");
  endtask : t_hdr

  task automatic t_cases();
    ard_bq_t c;
    c = rr(8'h02, 8'h2c, 8'h00);
    void'(c.pop_back());
    xfer(c, sw(16'h6700), C1);
    c.push_back(8'h02);
    c.push_back(8'haa);
    c.push_back(8'hbb);
    xfer(c, sw(16'h6700), C3);
    c.push_back(8'h00);
    xfer(c, sw(16'h6700), C4);
    c[4] = 8'h05;
    xfer(c, sw(16'h6700), CN);
    c = rr(8'h02, 8'h2c, 8'h00);
    c.push_back(8'h00);
    xfer(c, sw(16'h6700), CN);
    c = c[0:2];
    xfer(c, sw(16'h6700), CN);
    $display("t_cases done");
  endtask : t_cases

  task automatic t_midrst();
    @(posedge i_clk);
    #1;
    i_resetn = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    `CHK(o_cmd_ready, 1'b0)
    repeat (3) @(posedge i_clk);
    #1;
    `CHK(o_cmd_ready, 1'b1)
    `CHK(o_listing_present, 1'b0)
    xfer(rr(8'h02, 8'h2c, 8'h00), sw(16'h6a83), C2);
    $display("t_midrst done");
  endtask : t_midrst

  task automatic report_and_stop();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    i_resetn = 1'b0;
    i_ld_valid = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    t_reset();
    t_load();
    t_read();
    t_le();
    t_sfi();
    t_rec();
    t_hdr();
    t_cases();
    t_midrst();
    report_and_stop();
  end
endmodule : ard_top_tb
`default_nettype wire
